// ==== rtl/hcc_cfg.svh ====
/*
  Constants of the coil chopper: register offsets, field positions,
  reset values and timing counts in system clock cycles.
  Assumes a 32-bit register port with byte offsets on an 8-bit address.
*/
`ifndef HCC_CFG_SVH
`define HCC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HCC_ADDR_CTRL 8'h00
`define HCC_ADDR_SCALE 8'h04
`define HCC_ADDR_STATUS 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HCC_F_SLOW_DECAY_TIME 3:0
`define HCC_F_TBL 5:4
`define HCC_F_HYST_START_OFFSET 8:6
`define HCC_F_HYST_END_VALUE 12:9
`define HCC_F_CHM 13
`define HCC_F_SCALE 4:0
`define HCC_F_PHASE 2:0
`define HCC_F_HYST 13:8
`define HCC_F_CMP 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HCC_RST_SLOW_DECAY_TIME 4'h0
`define HCC_RST_TBL 2'h1
`define HCC_RST_HYST_START_OFFSET 3'h4
`define HCC_RST_HYST_END_VALUE 4'h7
`define HCC_RST_CHM 1'b0
`define HCC_RST_SCALE 5'h1f

// ----------------------------------------
// Timing, hysteresis and amplitude figures
// ----------------------------------------
`define HCC_SD_BASE 9'd12
`define HCC_SD_MULT 9'd32
`define HCC_BLANK_0 9'd16
`define HCC_BLANK_1 9'd24
`define HCC_BLANK_2 9'd36
`define HCC_BLANK_3 9'd54
`define HCC_DEC_CLKS 5'd16
`define HCC_HYST_START_OFFSET_BIAS 6'sd1
`define HCC_HYST_END_VALUE_BIAS 6'sd3
`define HCC_HYST_CAP 6'sd16
`define HCC_SCALE_REDUCED 5'd30
`define HCC_AMP_FULL 8'd248
`define HCC_AMP_REDUCED 8'd240

`endif

// ==== rtl/hcc_chopper.sv ====
/*
  Per-coil four-phase hysteresis chopper with its register port.
  Assumes the comparator pin is asynchronous and that its threshold is
  the target current during the on phase and target minus hyst_o during
  fast decay.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_cfg.svh"

module hcc_chopper
  import hcc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic cmp_i,
  output logic [31:0] rdata_o,
  output logic drive_on_o,
  output logic drive_fast_o,
  output logic drive_slow_o,
  output logic [5:0] hyst_o,
  output logic [7:0] amp_peak_o
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [8:0] slow_cycles(input logic [3:0] t);
    return `HCC_SD_BASE + `HCC_SD_MULT * {5'h00, t};
  endfunction : slow_cycles

  function automatic logic [8:0] blank_cycles(input logic [1:0] b);
    logic [8:0] n;
    case (b)
      2'h0: n = `HCC_BLANK_0;
      2'h1: n = `HCC_BLANK_1;
      2'h2: n = `HCC_BLANK_2;
      default: n = `HCC_BLANK_3;
    endcase
    return n;
  endfunction : blank_cycles

  function automatic logic signed [5:0] hyst_end_value_eff(input logic [3:0] e);
    return $signed({2'b00, e}) - `HCC_HYST_END_VALUE_BIAS;
  endfunction : hyst_end_value_eff

  function automatic logic signed [5:0] hyst_start(input logic [2:0] s,
      input logic [3:0] e, input logic [4:0] sc);
    logic signed [5:0] sum;
    sum = $signed({3'b000, s}) + `HCC_HYST_START_OFFSET_BIAS + hyst_end_value_eff(e);
    // Full amplitude leaves no headroom, so an oversize sum is capped
    if (sc > `HCC_SCALE_REDUCED && sum > `HCC_HYST_CAP) begin
      sum = `HCC_HYST_CAP;
    end
    return sum;
  endfunction : hyst_start

  function automatic hcc_phase_t phase_after(input hcc_phase_t p);
    hcc_phase_t n;
    case (p)
      hcc_ph_idle: n = hcc_ph_on;
      hcc_ph_on: n = hcc_ph_sd1;
      hcc_ph_sd1: n = hcc_ph_fd;
      hcc_ph_fd: n = hcc_ph_sd2;
      default: n = hcc_ph_on;
    endcase
    return n;
  endfunction : phase_after

  // ----------------------------------------
  // State and timers
  // ----------------------------------------
  hcc_state_t q;
  hcc_state_t d;
  logic blank_load;
  logic sd_load;
  logic start;
  logic run;
  logic blank_done;
  logic sd_done;

  hcc_timer u_blank (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .load_i(blank_load),
    .len_i(blank_cycles(q.blank_time_select)),
    .done_o(blank_done)
  );

  hcc_timer u_slow (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .load_i(sd_load),
    .len_i(slow_cycles(q.slow_decay_time)),
    .done_o(sd_done)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.cmp_meta = cmp_i;
    d.cmp_sync = q.cmp_meta;
    d.rdata = 32'h0000_0000;
    blank_load = 1'b0;
    sd_load = 1'b0;
    start = 1'b0;
    if (wr_i) begin
      case (addr_i)
        `HCC_ADDR_CTRL: begin
          d.slow_decay_time = wdata_i[`HCC_F_SLOW_DECAY_TIME];
          d.blank_time_select = wdata_i[`HCC_F_TBL];
          d.hyst_start_offset = wdata_i[`HCC_F_HYST_START_OFFSET];
          d.hyst_end_value = wdata_i[`HCC_F_HYST_END_VALUE];
          d.chm = wdata_i[`HCC_F_CHM];
        end
        `HCC_ADDR_SCALE: d.scale = wdata_i[`HCC_F_SCALE];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `HCC_ADDR_CTRL: begin
          d.rdata[`HCC_F_SLOW_DECAY_TIME] = q.slow_decay_time;
          d.rdata[`HCC_F_TBL] = q.blank_time_select;
          d.rdata[`HCC_F_HYST_START_OFFSET] = q.hyst_start_offset;
          d.rdata[`HCC_F_HYST_END_VALUE] = q.hyst_end_value;
          d.rdata[`HCC_F_CHM] = q.chm;
        end
        `HCC_ADDR_SCALE: d.rdata[`HCC_F_SCALE] = q.scale;
        `HCC_ADDR_STATUS: begin
          d.rdata[`HCC_F_PHASE] = q.st;
          d.rdata[`HCC_F_HYST] = q.hyst;
          d.rdata[`HCC_F_CMP] = q.cmp_sync;
        end
        default: ;
      endcase
    end
    run = (q.slow_decay_time != 4'h0) && !q.chm;
    case (q.st)
      hcc_ph_idle: begin
        d.st = hcc_ph_on;
        blank_load = 1'b1;
        start = 1'b1;
      end
      hcc_ph_on: begin
        if (blank_done && q.cmp_sync) begin
          d.st = hcc_ph_sd1;
          sd_load = 1'b1;
        end
      end
      hcc_ph_sd1: begin
        if (sd_done) begin
          d.st = hcc_ph_fd;
          blank_load = 1'b1;
        end
      end
      hcc_ph_fd: begin
        if (blank_done && q.cmp_sync) begin
          d.st = hcc_ph_sd2;
          sd_load = 1'b1;
        end
      end
      hcc_ph_sd2: begin
        if (sd_done) begin
          d.st = hcc_ph_on;
          blank_load = 1'b1;
          start = 1'b1;
        end
      end
      default: d.st = hcc_ph_idle;
    endcase
    // Zero off time or the other mode: all transistors off
    if (!run) begin
      d.st = hcc_ph_idle;
      blank_load = 1'b0;
      sd_load = 1'b0;
      start = 1'b0;
    end
    // Settings latched per cycle so a write mid-cycle cannot jump the floor
    if (start) begin
      d.hyst = hyst_start(q.hyst_start_offset, q.hyst_end_value, q.scale);
      d.hyst_end = hyst_end_value_eff(q.hyst_end_value);
      d.pre = 4'h0;
    end else if (q.st != hcc_ph_idle) begin
      d.pre = q.pre + 4'h1;
      if (q.pre == 4'(`HCC_DEC_CLKS - 5'd1) && q.hyst > q.hyst_end) begin
        d.hyst = q.hyst - 6'sd1;
      end
    end
    d.drv_on = (d.st == hcc_ph_on);
    d.drv_fast = (d.st == hcc_ph_fd);
    d.drv_slow = (d.st == hcc_ph_sd1) || (d.st == hcc_ph_sd2);
    d.amp = (q.scale <= `HCC_SCALE_REDUCED) ? `HCC_AMP_REDUCED : `HCC_AMP_FULL;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.slow_decay_time <= `HCC_RST_SLOW_DECAY_TIME;
      q.blank_time_select <= `HCC_RST_TBL;
      q.hyst_start_offset <= `HCC_RST_HYST_START_OFFSET;
      q.hyst_end_value <= `HCC_RST_HYST_END_VALUE;
      q.chm <= `HCC_RST_CHM;
      q.scale <= `HCC_RST_SCALE;
      q.st <= hcc_ph_idle;
      q.amp <= `HCC_AMP_FULL;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign drive_on_o = q.drv_on;
  assign drive_fast_o = q.drv_fast;
  assign drive_slow_o = q.drv_slow;
  assign hyst_o = q.hyst;
  assign amp_peak_o = q.amp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [8:0] sd_len;
  logic [8:0] sd_exp;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sd_len <= 9'd0;
      sd_exp <= 9'd0;
    end else begin
      sd_len <= q.drv_slow ? sd_len + 9'd1 : 9'd0;
      if (sd_load) begin
        sd_exp <= slow_cycles(q.slow_decay_time);
      end
    end
  end

  a_phase_order: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (q.st != $past(q.st)) |-> (q.st == hcc_ph_idle || q.st == phase_after($past(q.st))))
    else $error("chopper phase out of order");

  a_blank_mask: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (($past(q.st) == hcc_ph_on || $past(q.st) == hcc_ph_fd) && q.drv_slow)
      |-> $past(blank_done))
    else $error("phase ended during blanking");

  a_hyst_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ($past(start)) |-> (q.hyst == hyst_start($past(q.hyst_start_offset), $past(q.hyst_end_value), $past(q.scale))))
    else $error("hysteresis not loaded at cycle start");

  a_hyst_step: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!$past(start) && q.hyst != $past(q.hyst))
      |-> ($past(q.pre) == 4'hf && q.hyst == $past(q.hyst) - 6'sd1))
    else $error("hysteresis stepped off the 16 clock grid");

  a_hyst_floor: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (q.st != hcc_ph_idle && !$past(start) && $past(q.hyst) <= $past(q.hyst_end))
      |-> (q.hyst == $past(q.hyst)))
    else $error("hysteresis went below end value");

  a_end_decode: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $past(start) |-> (q.hyst_end == $signed({2'b00, $past(q.hyst_end_value)}) - 6'sd3))
    else $error("end value decoded wrongly");

  a_slow_time: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ($past(q.drv_slow) && !q.drv_slow && q.st != hcc_ph_idle)
      |-> ($past(sd_len) == $past(sd_exp) - 9'd1))
    else $error("slow decay length wrong");

  a_freewheel_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (q.slow_decay_time == 4'h0) |=> (!drive_on_o && !drive_fast_o && !drive_slow_o))
    else $error("bridge driven with zero off time");

  a_mode_select: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    q.chm |=> (q.st == hcc_ph_idle))
    else $error("chopper ran in the other mode");

  a_amp_limit: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (q.scale <= 5'd30) |=> (amp_peak_o == 8'd240))
    else $error("amplitude not reduced");

endmodule : hcc_chopper
`default_nettype wire

// ==== rtl/hcc_pkg.sv ====
/*
  Types of the coil chopper: phase encoding and the state records.
  Assumes the constants header is included where figures are needed.
*/
package hcc_pkg;

  // ----------------------------------------
  // Chopper phases, Gray along on-slow-fast-slow
  // ----------------------------------------
  typedef enum logic [2:0] {
    hcc_ph_idle = 3'b000,
    hcc_ph_on = 3'b001,
    hcc_ph_sd1 = 3'b011,
    hcc_ph_fd = 3'b010,
    hcc_ph_sd2 = 3'b110
  } hcc_phase_t;

  typedef struct packed {
    logic cmp_meta;
    logic cmp_sync;
    logic [3:0] slow_decay_time;
    logic [1:0] blank_time_select;
    logic [2:0] hyst_start_offset;
    logic [3:0] hyst_end_value;
    logic chm;
    logic [4:0] scale;
    hcc_phase_t st;
    logic signed [5:0] hyst;
    logic signed [5:0] hyst_end;
    logic [3:0] pre;
    logic [31:0] rdata;
    logic drv_on;
    logic drv_fast;
    logic drv_slow;
    logic [7:0] amp;
  } hcc_state_t;

  typedef struct packed {
    logic [8:0] cnt;
  } hcc_timer_state_t;

endpackage : hcc_pkg

// ==== rtl/hcc_timer.sv ====
/*
  Down counter for blanking and slow decay intervals.
  Assumes load is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module hcc_timer
  import hcc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [8:0] len_i,
  output logic done_o
);

  hcc_timer_state_t q;
  hcc_timer_state_t d;

  // Loads len-1 so an interval of len cycles ends exactly on time
  always_comb begin
    d = q;
    if (load_i) begin
      d.cnt = len_i - 9'd1;
    end else if (q.cnt != 9'd0) begin
      d.cnt = q.cnt - 9'd1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = (q.cnt == 9'd0) && !load_i;

endmodule : hcc_timer
`default_nettype wire

// ==== testbench/hcc_bridge_model.sv ====
/*
  Behavioural coil bridge with sense comparator for the chopper.
  Assumes one high drive level at a time; delay_i sets how fast current moves.
*/
`timescale 1ns/1ps
`default_nettype none

module hcc_bridge_model
  import hcc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic drive_on_i,
  input wire logic drive_fast_i,
  input wire logic drive_slow_i,
  input wire logic [9:0] delay_i,
  output logic cmp_o
);
  logic [2:0] last;
  logic [9:0] cnt;

  // ----------------------------------------
  // Cycles since the bridge last switched
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last <= 3'h0;
      cnt <= 10'h000;
    end else begin
      last <= {drive_on_i, drive_fast_i, drive_slow_i};
      if (last != {drive_on_i, drive_fast_i, drive_slow_i}) begin
        cnt <= 10'h000;
      end else if (cnt != 10'h3ff) begin
        cnt <= cnt + 10'h001;
      end
    end
  end

  // No sense current in slow decay: output toggles, chopper must ignore it
  assign cmp_o = (drive_on_i | drive_fast_i) ? (cnt >= delay_i) : cnt[0];
endmodule : hcc_bridge_model

`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for the coil chopper and its register port.
  Assumes the bridge model answers delay cycles after each switch.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hcc_cfg.svh"

module tb_top
  import hcc_pkg::*;
;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic cmp_i;
  logic [31:0] rdata_o;
  logic drive_on_o;
  logic drive_fast_o;
  logic drive_slow_o;
  logic [5:0] hyst_o;
  logic [7:0] amp_peak_o;
  logic [9:0] delay = 10'h003;
  int failures = 0;
  int compares = 0;

  always #5 clock_i = ~clock_i;

  hcc_chopper i_dut (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .cmp_i,
    .rdata_o, .drive_on_o, .drive_fast_o, .drive_slow_o, .hyst_o, .amp_peak_o);

  hcc_bridge_model i_bridge (.clock_i, .sys_rst_i, .drive_on_i(drive_on_o),
    .drive_fast_i(drive_fast_o), .drive_slow_i(drive_slow_o), .delay_i(delay),
    .cmp_o(cmp_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_count(input string n, input int e, input int g);
    compares++;
    if (g != e) begin
      failures++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_count

  task automatic step;
    @(posedge clock_i);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    // Step off the edge so callers read the outputs it launches, not the old ones
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  function automatic logic pick(input int sel);
    return (sel == 0) ? drive_on_o : (sel == 1) ? drive_fast_o : drive_slow_o;
  endfunction : pick

  task automatic until_on(input logic v);
    int i;
    for (i = 0; i < 3000 && drive_on_o !== v; i++) step;
    if (i == 3000) begin
      failures++;
      $display("Error drive_on_wait expected %0b seen %0b", v, drive_on_o);
    end
  endtask : until_on

  task automatic next_on;
    until_on(1'b0);
    until_on(1'b1);
  endtask : next_on

  // Counts cycles the chosen drive stays high; bounded so a stuck phase ends
  task automatic span(input int sel, output int n);
    n = 0;
    while (pick(sel) === 1'b1 && n < 3000) begin
      n++;
      step;
    end
  endtask : span

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    chk_word("drives", 32'h0, 32'({drive_on_o, drive_fast_o, drive_slow_o}));
    chk_word("amp", 32'hf8, 32'(amp_peak_o));
    rd(`HCC_ADDR_CTRL, d);
    chk_word("ctrl", 32'hf10, d);
    rd(`HCC_ADDR_SCALE, d);
    chk_word("scale", 32'h1f, d);
    step;
    chk_word("rdata_idle", 32'h0, rdata_o);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, d);
    chk_word("unmapped", 32'h0, d);
  endtask : t_reset

  task automatic t_cycle;
    int n;
    wr(`HCC_ADDR_CTRL, 32'he81);
    next_on;
    chk_word("hyst_start", 32'h7, 32'(hyst_o));
    span(0, n);
    chk_count("on_len", 16, n);
    chk_word("ph_sd1", 32'h1, 32'(drive_slow_o));
    span(2, n);
    chk_count("sd1_len", 44, n);
    chk_word("ph_fd", 32'h1, 32'(drive_fast_o));
    span(1, n);
    chk_count("fd_len", 16, n);
    chk_word("ph_sd2", 32'h1, 32'(drive_slow_o));
    span(2, n);
    chk_count("sd2_len", 44, n);
    chk_word("ph_on", 32'h1, 32'(drive_on_o));
    chk_word("hyst_reload", 32'h7, 32'(hyst_o));
  endtask : t_cycle

  task automatic t_decay;
    int i;
    delay <= 10'h05a;
    next_on;
    repeat (8) step;
    for (i = 0; i < 5; i++) begin
      chk_word("hyst_dec", 32'(i < 4 ? 7 - i : 4), 32'(hyst_o));
      repeat (16) step;
    end
    chk_word("on_held", 32'h1, 32'(drive_on_o));
    delay <= 10'h003;
  endtask : t_decay

  task automatic t_blank;
    int b[4] = '{16, 24, 36, 54};
    int t;
    int n;
    for (t = 0; t < 4; t++) begin
      wr(`HCC_ADDR_CTRL, 32'he81 | 32'(t << 4));
      next_on;
      span(0, n);
      chk_count("blank_len", b[t], n);
    end
  endtask : t_blank

  task automatic t_decode;
    wr(`HCC_ADDR_SCALE, 32'h1e);
    repeat (2) step;
    chk_word("amp_low", 32'hf0, 32'(amp_peak_o));
    wr(`HCC_ADDR_CTRL, 32'h1fc1);
    next_on;
    chk_word("hyst_wide", 32'h14, 32'(hyst_o));
    wr(`HCC_ADDR_CTRL, 32'h001);
    next_on;
    chk_word("hyst_neg", 32'h3e, 32'(hyst_o));
    wr(`HCC_ADDR_SCALE, 32'h1f);
    repeat (2) step;
    chk_word("amp_full", 32'hf8, 32'(amp_peak_o));
    // Full amplitude: an oversize start of 20 is held at 16
    wr(`HCC_ADDR_CTRL, 32'h1fc1);
    next_on;
    chk_word("hyst_cap", 32'h10, 32'(hyst_o));
  endtask : t_decode

  task automatic t_idle;
    logic [31:0] d;
    wr(`HCC_ADDR_CTRL, 32'he80);
    repeat (60) step;
    chk_word("freewheel", 32'h0, 32'({drive_on_o, drive_fast_o, drive_slow_o}));
    wr(`HCC_ADDR_CTRL, 32'h2e81);
    repeat (60) step;
    chk_word("other_mode", 32'h0, 32'({drive_on_o, drive_fast_o, drive_slow_o}));
    rd(`HCC_ADDR_STATUS, d);
    chk_word("phase_idle", 32'h0, d & 32'h7);
  endtask : t_idle

  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    step;
    t_reset;
    t_cycle;
    t_decay;
    t_blank;
    t_decode;
    t_idle;
    summarize;
  end

  // Whole run needs a few thousand cycles; this margin only trips on a hang
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    summarize;
  end
endmodule : tb_top

`default_nettype wire
